// ---- design/sdadc_seq.sv ----
// Delta-sigma converter sequencer: APB registers, start logic,
// four-tap decimator, result FIFO and the conversion done output.
// Assumes the modulator bit and trigger arrive from outside the clock
// domain and that the APB master follows the usual two-phase protocol.
//
// Function
// - Decimator output depends on last four samples.
// - Data invalid until fourth sample after mux change.
// - Four modes: single, multi, continuous, turbo.
// - Start by start bit or trigger input.
// - On completion set status bit, raise done.
// - Done stays high until result read.
// - Single mode idles in standby awaiting trigger.
// - Each single trigger runs four conversions.
// - First three conversions only prime, unreported.
// - Result valid after fourth, done raised then.
// - After read, return to standby until trigger.
// - Resolution traded against output rate in turbo mode only.
// - Serial bit stream converted to parallel words.
// - Mux selects at most one input at once.
// - Continuous first result on the fourth conversion.
`timescale 1ns/100ps
`include "sdadc_cfg.svh"
module sdadc_seq #(
    parameter int FIFO_DEPTH = 16,
    parameter int MUX_INPUTS = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mod_bit,
    input wire logic conv_trig,
    output logic conv_done,
    output logic [MUX_INPUTS-1:0] mux_sel_onehot,
    output logic [3:0] shared_analog_bus_sw
);
    localparam int MW = $clog2(MUX_INPUTS);

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    logic [1:0] bit_sync_q;
    logic [1:0] trig_sync_q;
    logic trig_prev_q;

    // Two stages each; only the second stage is read by logic.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_sync_q <= 2'h0;
            trig_sync_q <= 2'h0;
            trig_prev_q <= 1'b0;
        end else if (ce) begin
            bit_sync_q <= {bit_sync_q[0], mod_bit};
            trig_sync_q <= {trig_sync_q[0], conv_trig};
            trig_prev_q <= trig_sync_q[1];
        end
    end
    wire trig_rise = trig_sync_q[1] && !trig_prev_q;

    // ************************************************************
    // Register file.
    // ************************************************************
    logic [5:0] ctrl_q;
    logic [15:0] div_q;
    logic [MW-1:0] mux_q;
    logic [3:0] sw_q;
    logic ovf_q;
    sdadc_pkg::sdadc_state_t st_q;
    sdadc_pkg::sdadc_state_t st_d;

    // Address decode as named wires.
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = (paddr == `SDADC_OFS_CTRL);
    wire hit_stat = (paddr == `SDADC_OFS_STAT);
    wire hit_res = (paddr == `SDADC_OFS_RES);
    wire hit_div = (paddr == `SDADC_OFS_DIV);
    wire hit_mux = (paddr == `SDADC_OFS_MUX);
    wire hit_any = hit_ctrl || hit_stat || hit_res || hit_div || hit_mux;
    wire sdadc_pkg::sdadc_mode_t mode =
        sdadc_pkg::sdadc_mode_t'(
            ctrl_q[`SDADC_CTRL_MODE_HI:`SDADC_CTRL_MODE_LO]);
    wire sdadc_pkg::sdadc_res_t resl =
        sdadc_pkg::sdadc_res_t'(
            ctrl_q[`SDADC_CTRL_RES_HI:`SDADC_CTRL_RES_LO]);
    wire sw_start = wr && hit_ctrl && pwdata[`SDADC_CTRL_START];
    wire sw_stop = wr && hit_ctrl && pwdata[`SDADC_CTRL_STOP];
    wire mux_wr = wr && hit_mux;
    // A start written together with a mode uses the new mode at once.
    wire sdadc_pkg::sdadc_mode_t start_mode = sdadc_pkg::sdadc_mode_t'(
        (wr && hit_ctrl) ? pwdata[`SDADC_CTRL_MODE_HI:`SDADC_CTRL_MODE_LO]
        : ctrl_q[`SDADC_CTRL_MODE_HI:`SDADC_CTRL_MODE_LO]);
    wire busy = (st_q != sdadc_pkg::SDADC_STANDBY);

    // A start bit and a trigger edge collapse into one pulse.
    wire start_pulse = (sw_start || trig_rise) && !busy;

    // Control writes; the start bit is self-clearing and never stored.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 6'h00;
            div_q <= `SDADC_DIV_RST;
            mux_q <= '0;
            sw_q <= 4'h0;
        end else if (ce) begin
            if (wr && hit_ctrl) begin
                ctrl_q <= {1'b0,
                    pwdata[`SDADC_CTRL_RES_HI:`SDADC_CTRL_MODE_LO], 1'b0};
            end
            if (wr && hit_div) begin
                div_q <= (pwdata[15:0] == 16'h0) ? 16'h0001 : pwdata[15:0];
            end
            if (mux_wr) begin
                mux_q <= pwdata[MW-1:0];
                sw_q <= pwdata[19:16];
            end
        end
    end

    // One-hot decode keeps exactly one mux input on; the switch group
    // may close several at once.
    function automatic logic [MUX_INPUTS-1:0] onehot(input logic [MW-1:0] i);
        onehot = '0;
        onehot[i] = 1'b1;
    endfunction

    // ************************************************************
    // Modulator sample timing.
    // ************************************************************
    logic [15:0] div_cnt_q;
    logic [15:0] acc_cnt_q;
    logic [15:0] integ_q;
    // A divider cut below the running count ends the period at once,
    // rather than after a wrap of the whole counter.
    wire samp_tick = (div_cnt_q >= div_q - 16'h0001);

    // Integrate the serial stream over one sample period.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 16'h0;
            acc_cnt_q <= 16'h0;
            integ_q <= 16'h0;
        end else if (ce) begin
            div_cnt_q <= samp_tick ? 16'h0 : div_cnt_q + 16'h0001;
            acc_cnt_q <= samp_tick ? 16'h0 : acc_cnt_q + 16'(bit_sync_q[1]);
            integ_q <= samp_tick ? acc_cnt_q + 16'(bit_sync_q[1]) : integ_q;
        end
    end

    // ************************************************************
    // Four-tap decimator pipeline.
    // ************************************************************
    logic [15:0] tap_q [`SDADC_TAPS];
    logic [2:0] prime_q;
    logic conv_tick;
    logic reprime;
    assign conv_tick = ce && samp_tick && busy
        && (st_q != sdadc_pkg::SDADC_WAITRD);

    // Sum of the four newest integrator words.
    wire [17:0] dec_sum = 18'(tap_q[0]) + 18'(tap_q[1])
        + 18'(tap_q[2]) + 18'(tap_q[3]);

    // Resolution sets how many bits of the sum are reported.
    function automatic logic [31:0] trim(input logic [17:0] s,
                                         input sdadc_pkg::sdadc_res_t r);
        case (r)
            sdadc_pkg::SDADC_R16: trim = {16'h0, s[17:2]};
            sdadc_pkg::SDADC_R12: trim = {20'h0, s[17:6]};
            sdadc_pkg::SDADC_R8: trim = {24'h0, s[17:10]};
            default: trim = {14'h0, s};
        endcase
    endfunction

    // Taps shift per conversion; a mux change or fresh start re-primes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < `SDADC_TAPS; k++) begin
                tap_q[k] <= 16'h0;
            end
            prime_q <= 3'h0;
        end else if (ce) begin
            if (mux_wr || start_pulse) begin
                prime_q <= 3'h0;
            end else if (conv_tick) begin
                tap_q[0] <= integ_q;
                for (int k = 1; k < `SDADC_TAPS; k++) begin
                    tap_q[k] <= tap_q[k-1];
                end
                if (reprime) begin
                    prime_q <= 3'h0;
                end else if (prime_q != `SDADC_PRIME_CNT + 3'h1) begin
                    prime_q <= prime_q + 3'h1;
                end
            end
        end
    end

    // Conversions 1..3 only prime; the fourth reports, and later ones until a re-prime.
    wire primed = (prime_q >= `SDADC_PRIME_CNT);
    wire result_now = conv_tick && primed && !mux_wr;

    // ************************************************************
    // Result FIFO and read side.
    // ************************************************************
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    wire res_read = rd && hit_res && fifo_out_valid;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    logic [LW-1:0] fifo_level;
    // Done falls with the pop of the last waiting word or a flush by a new start.
    wire last_pop = res_read && (fifo_level == LW'(1));

    sdadc_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .flush(start_pulse), // A stop keeps unread words.
        .in_valid(result_now),
        .in_ready(fifo_in_ready),
        .in_data(trim(dec_sum, resl)),
        .out_valid(fifo_out_valid),
        .out_ready(res_read),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // ************************************************************
    // Sequencer.
    // ************************************************************
    // Single mode: four conversions then wait for the read; the other
    // modes keep converting and never stall; a result that meets a full FIFO is dropped and sets overflow.
    always_comb begin
        st_d = st_q;
        case (st_q)
            sdadc_pkg::SDADC_STANDBY: begin
                if (start_pulse) begin
                    st_d = (start_mode == sdadc_pkg::SDADC_SINGLE)
                        ? sdadc_pkg::SDADC_CONVERT : sdadc_pkg::SDADC_RUN;
                end
            end
            sdadc_pkg::SDADC_CONVERT: begin
                if (result_now) begin
                    st_d = sdadc_pkg::SDADC_WAITRD;
                end
            end
            sdadc_pkg::SDADC_WAITRD: begin
                if (res_read || !fifo_out_valid) begin
                    st_d = sdadc_pkg::SDADC_STANDBY;
                end
            end
            sdadc_pkg::SDADC_RUN: begin
                if (sw_stop) begin
                    st_d = sdadc_pkg::SDADC_STANDBY;
                end
            end
            default: st_d = sdadc_pkg::SDADC_STANDBY;
        endcase
        if (sw_stop) begin
            st_d = sdadc_pkg::SDADC_STANDBY;
        end
    end

    // Multi mode re-primes after each result; turbo re-primes only at 20 bits.
    assign reprime = result_now && ((mode == sdadc_pkg::SDADC_MULTI)
        || (mode == sdadc_pkg::SDADC_TURBO
            && resl == sdadc_pkg::SDADC_R20));

    // State register and overflow flag; set wins over the clear.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= sdadc_pkg::SDADC_STANDBY;
            ovf_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            if (result_now && !fifo_in_ready) begin
                ovf_q <= 1'b1;
            end else if (rd && hit_stat) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Bus answer and outputs.
    // ************************************************************
    wire [31:0] stat_word = {28'h0, ovf_q, primed, busy, fifo_out_valid};
    wire [31:0] rd_word =
        hit_ctrl ? {26'h0, ctrl_q} :
        hit_stat ? stat_word :
        hit_res ? fifo_out_data :
        hit_div ? {16'h0, div_q} :
        hit_mux ? {12'h0, sw_q, 16'(mux_q)} : `SDADC_ERR_WORD;

    // Registered answer: no wait state, pready in the first access
    // cycle; the done output tracks the FIFO holding a result.
    // Reset selects input zero, matching the reset mux register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            conv_done <= 1'b0;
            mux_sel_onehot <= MUX_INPUTS'(1);
            shared_analog_bus_sw <= 4'h0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= rd_word;
            conv_done <= result_now || (fifo_out_valid && !last_pop);
            mux_sel_onehot <= onehot(mux_q);
            shared_analog_bus_sw <= sw_q;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    sequence start_seen;
        start_pulse;
    endsequence

    one_mux_a: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot(mux_sel_onehot)) else $error("mux not one-hot");

    busy_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && st_q == sdadc_pkg::SDADC_CONVERT && (sw_start || trig_rise)
            && !sw_stop && !mux_wr && !conv_tick)
        |=> (st_q == sdadc_pkg::SDADC_CONVERT && $stable(prime_q)))
        else $error("start while busy");

    single_go_a: assert property (@(posedge ref_clk) disable iff (rst)
        (start_seen and (ce && !sw_stop
            && start_mode == sdadc_pkg::SDADC_SINGLE))
        |=> st_q == sdadc_pkg::SDADC_CONVERT)
        else $error("single did not start");

    prime_block_a: assert property (@(posedge ref_clk) disable iff (rst)
        (conv_tick && prime_q < `SDADC_PRIME_CNT) |-> !result_now)
        else $error("priming result reported");

    done_raise_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && result_now) |=> conv_done)
        else $error("done not raised");

    done_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && fifo_out_valid && !res_read && conv_done) |=> conv_done)
        else $error("done dropped unread");

    back_stby_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && st_q == sdadc_pkg::SDADC_WAITRD && res_read)
        |=> st_q == sdadc_pkg::SDADC_STANDBY)
        else $error("no return to standby");

    pready_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && psel && !penable) ##1 (ce && psel && penable) |-> pready)
        else $error("late apb answer");
endmodule

// ---- design/sdadc_cfg.svh ----
// Constants for the delta-sigma converter sequencer: register map,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design file and both bench files.
`ifndef SDADC_CFG_SVH
`define SDADC_CFG_SVH

// ************************************************************
// Register offsets (byte addresses on APB).
// ************************************************************
`define SDADC_OFS_CTRL 12'h000
`define SDADC_OFS_STAT 12'h004
`define SDADC_OFS_RES 12'h008
`define SDADC_OFS_DIV 12'h00C
`define SDADC_OFS_MUX 12'h010

// ************************************************************
// Control field positions.
// ************************************************************
`define SDADC_CTRL_START 0
`define SDADC_CTRL_MODE_LO 1
`define SDADC_CTRL_MODE_HI 2
`define SDADC_CTRL_RES_LO 3
`define SDADC_CTRL_RES_HI 4
`define SDADC_CTRL_STOP 5

// ************************************************************
// Status field positions.
// ************************************************************
`define SDADC_STAT_DONE 0
`define SDADC_STAT_BUSY 1
`define SDADC_STAT_VALID 2
`define SDADC_STAT_OVF 3

// ************************************************************
// Reset values and counts.
// ************************************************************
`define SDADC_DIV_RST 16'h0040
`define SDADC_PRIME_CNT 3'h3
`define SDADC_TAPS 4
`define SDADC_TURBO_FACTOR 2'h3
`define SDADC_ERR_WORD 32'h0000_0000

`endif

// ---- design/sdadc_pkg.sv ----
// Types shared by the sequencer: modes, resolutions and states.
// Assumes the constants header is compiled alongside.
package sdadc_pkg;

    // Operating modes as written to the mode field.
    typedef enum logic [1:0] {
        SDADC_SINGLE = 2'h0,
        SDADC_MULTI = 2'h1,
        SDADC_CONT = 2'h2,
        SDADC_TURBO = 2'h3
    } sdadc_mode_t;

    // Result resolution choices.
    typedef enum logic [1:0] {
        SDADC_R20 = 2'h0,
        SDADC_R16 = 2'h1,
        SDADC_R12 = 2'h2,
        SDADC_R8 = 2'h3
    } sdadc_res_t;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        SDADC_STANDBY = 4'h1,
        SDADC_CONVERT = 4'h2,
        SDADC_WAITRD = 4'h4,
        SDADC_RUN = 4'h8
    } sdadc_state_t;

endpackage

// ---- design/sdadc_fifo.sv ----
// Synchronous result FIFO with valid/ready on both sides.
// Assumes one clock, an active-high async reset and a clock enable.
`timescale 1ns/100ps
module sdadc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];
    assign level = cnt_q;

    // Storage has no reset; only pointers and count do.
    always_ff @(posedge ref_clk) begin
        if (ce && push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointer and count update, cleared by a flush.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (flush) begin
                wp_q <= '0;
                rp_q <= '0;
                cnt_q <= '0;
            end else begin
                wp_q <= push ? wp_q + AW'(1) : wp_q;
                rp_q <= pop ? rp_q + AW'(1) : rp_q;
                cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end
endmodule

// ---- tb/sdadc_reader.sv ----
// Partner model: the CPU or DMA reader that talks to the sequencer on APB.
// Assumes one clock and that this module alone drives the APB request.
`timescale 1ns/100ps
`include "sdadc_cfg.svh"
module sdadc_reader (
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_done
);
    // The bus starts idle with a recognisable pattern on address and data.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hFFF;
        pwdata = 32'hA5A5_A5A5;
    end

    // One transfer, held until pready is sampled high at a rising edge.
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only pready or the bench timeout ends this wait.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata; // Taken at the edge that saw pready.
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines change, so a stale value is never mistaken for data.
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    // Waits for the done output, then takes the result word.
    task automatic take_result(output logic [31:0] rd, output logic err);
        while (conv_done !== 1'b1) begin
            @(posedge ref_clk);
        end
        xfer(1'b0, `SDADC_OFS_RES, 32'h0, rd, err);
    endtask
endmodule

// ---- tb/sigma_delta_adc_sequencer_test.sv ----
// Self-checking bench for the converter sequencer and its result FIFO.
// Assumes the reader model owns the APB request lines.
`timescale 1ns/100ps
`include "sdadc_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; \
    if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module sigma_delta_adc_sequencer_test;
    localparam int DIV = 8;
    typedef struct {
        logic wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } sdadc_row_t;
    logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic mod_bit, conv_trig, conv_done, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] mux_sel_onehot;
    logic [3:0] shared_analog_bus_sw;
    int failures, samples_checked, cycles, n;
    // Writing zero to the divider must read back as one.
    sdadc_row_t rows[10] = '{
        '{1'b0, `SDADC_OFS_DIV, 32'h0, 32'h0000_0040, 1'b0},
        '{1'b0, `SDADC_OFS_STAT, 32'h0, 32'h0000_0000, 1'b0},
        '{1'b1, `SDADC_OFS_DIV, 32'h0, 32'h0, 1'b0},
        '{1'b0, `SDADC_OFS_DIV, 32'h0, 32'h0000_0001, 1'b0},
        '{1'b1, `SDADC_OFS_DIV, 32'h8, 32'h0, 1'b0},
        '{1'b0, `SDADC_OFS_DIV, 32'h0, 32'h0000_0008, 1'b0},
        '{1'b1, `SDADC_OFS_MUX, 32'h0005_0003, 32'h0, 1'b0},
        '{1'b0, `SDADC_OFS_MUX, 32'h0, 32'h0005_0003, 1'b0},
        '{1'b0, 12'h014, 32'h0, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h020, 32'h1, 32'h0, 1'b1}
    };

    sdadc_seq #(.FIFO_DEPTH(16), .MUX_INPUTS(8)) u_sdadc_seq (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mod_bit(mod_bit), .conv_trig(conv_trig),
        .conv_done(conv_done), .mux_sel_onehot(mux_sel_onehot),
        .shared_analog_bus_sw(shared_analog_bus_sw));
    sdadc_reader u_sdadc_reader (
        .ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done));

    // The clock toggles every half period of 5 ns.
    always #5 ref_clk = ~ref_clk;

    // A hang ends the run as a mismatch; the tests need about 750 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Counts cycles until the done output rises; the timeout bounds it.
    task automatic wait_done(output int k);
        k = 0;
        while (conv_done !== 1'b1) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_sdadc_reader.xfer(1'b1, a, d, rd, err);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        mod_bit = 1'b0;
        conv_trig = 1'b0;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(posedge ref_clk);
        `CHK("done in reset", 1'b0, conv_done)
        `CHK("mux in reset", 8'h01, mux_sel_onehot)
        rst <= 1'b0;
        // Register rows: reset values, divider floor, mux, unmapped places.
        foreach (rows[i]) begin
            u_sdadc_reader.xfer(rows[i].wr, rows[i].a, rows[i].d, rd, err);
            `CHK("slverr", rows[i].err, err)
            if (!rows[i].wr) `CHK("rdata", rows[i].exp, rd)
        end
        `CHK("mux select", 8'h08, mux_sel_onehot)
        `CHK("switch group", 4'h5, shared_analog_bus_sw)
        // Single mode by trigger: standby, four conversions, then result.
        wr(`SDADC_OFS_CTRL, 32'h0);
        repeat (8 * DIV) @(posedge ref_clk);
        `CHK("standby", 1'b0, conv_done)
        conv_trig <= 1'b1;
        repeat (3) @(posedge ref_clk);
        conv_trig <= 1'b0;
        wait_done(n);
        `CHK("priming", 1'b1, n + 3 > 3 * DIV)
        `CHK("done time", 1'b1, n + 3 <= 4 * DIV + 10)
        u_sdadc_reader.xfer(1'b0, `SDADC_OFS_STAT, 32'h0, rd, err);
        `CHK("status", 2'b11, {rd[2], rd[0]})
        u_sdadc_reader.take_result(rd, err);
        `CHK("zero stream", 32'h0, rd)
        repeat (2) @(posedge ref_clk);
        `CHK("done after read", 1'b0, conv_done)
        repeat (8 * DIV) @(posedge ref_clk);
        `CHK("back to standby", 1'b0, conv_done)
        u_sdadc_reader.xfer(1'b0, `SDADC_OFS_STAT, 32'h0, rd, err);
        `CHK("not busy", 1'b0, rd[1])
        // Start bit, then a second start while busy must not restart.
        mod_bit <= 1'b1;
        wr(`SDADC_OFS_CTRL, 32'h1);
        repeat (3 * DIV - 4) @(posedge ref_clk);
        wr(`SDADC_OFS_CTRL, 32'h1);
        wait_done(n);
        `CHK("no restart", 1'b1, n + 3 * DIV <= 4 * DIV + 10)
        u_sdadc_reader.take_result(rd, err);
        `CHK("ones stream", 1'b1, rd != 32'h0)
        // Continuous: first result after priming, then fill the FIFO.
        wr(`SDADC_OFS_CTRL, 32'h5);
        wait_done(n);
        `CHK("cont first", 1'b1, n >= 3 * DIV - 2)
        `CHK("cont bound", 1'b1, n <= 4 * DIV + 10)
        repeat (24 * DIV) @(posedge ref_clk);
        u_sdadc_reader.xfer(1'b0, `SDADC_OFS_STAT, 32'h0, rd, err);
        `CHK("overflow", 1'b1, rd[3])
        wr(`SDADC_OFS_MUX, 32'h1);
        u_sdadc_reader.xfer(1'b0, `SDADC_OFS_STAT, 32'h0, rd, err);
        `CHK("reprime", 1'b0, rd[2])
        `CHK("mux one-hot", 8'h02, mux_sel_onehot)
        wr(`SDADC_OFS_CTRL, 32'h24);
        // Drain all sixteen words; done holds until the last one goes.
        for (int i = 0; i < 16; i++) begin
            repeat (2) @(posedge ref_clk);
            `CHK("words waiting", 1'b1, conv_done)
            u_sdadc_reader.xfer(1'b0, `SDADC_OFS_RES, 32'h0, rd, err);
        end
        repeat (2) @(posedge ref_clk);
        `CHK("drained", 1'b0, conv_done)
        // Multi and turbo modes, each with its own resolution code.
        for (int m = 1; m < 4; m += 2) begin
            wr(`SDADC_OFS_CTRL, {27'h0, m[1:0], m[1:0], 1'b1});
            repeat (2) @(posedge ref_clk);
            wait_done(n);
            `CHK("mode start", 1'b1, n <= 4 * DIV + 10)
            wr(`SDADC_OFS_CTRL, {27'h1, m[1:0], m[1:0], 1'b0});
        end
        // Frozen clock enable: a trigger pulse in that time is never seen.
        ce <= 1'b0;
        conv_trig <= 1'b1;
        repeat (4 * DIV) @(posedge ref_clk);
        conv_trig <= 1'b0;
        repeat (2) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (8 * DIV) @(posedge ref_clk);
        u_sdadc_reader.xfer(1'b0, `SDADC_OFS_STAT, 32'h0, rd, err);
        `CHK("frozen trigger", 1'b0, rd[1])
        conclude();
    end
endmodule
